// file: shared/dpc_pkg.sv
/*
  dpc_pkg: constants of the dual pulse counter.
  Assumes one 250 MHz clock and a 32-bit AXI4-Lite register bus.
*/
package dpc_pkg;
  // structure
  localparam int NUM_CH    = 2;
  localparam int FIELD_W   = 8;
  localparam int CFG_PINS  = 6;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_DEBOUNCE  = 8'h04;
  localparam logic [7:0] OFS_GP_SELECT = 8'h08;
  localparam logic [7:0] OFS_COUNT1    = 8'h0C;
  localparam logic [7:0] OFS_COUNT2    = 8'h10;
  localparam logic [7:0] OFS_POINTS    = 8'h14;
  // control field positions, channel 2 sits CH_STRIDE above channel 1
  localparam int CTRL_SOFT_EN   = 0;
  localparam int CTRL_SOFT_CLR  = 1;
  localparam int CTRL_EN_ALLOW  = 2;
  localparam int CTRL_CLR_ALLOW = 3;
  localparam int CH_STRIDE      = 8;
  // pin roles while a pin serves the counters
  localparam int PIN_PULSE = 0;
  localparam int PIN_EXT_EN = 1;
  localparam int PIN_EXT_CLR = 2;
  localparam int PIN_STRIDE = 3;
  // values after reset
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [5:0]  GP_SELECT_RESET = 6'h00;
  // debounce codes and highest countable rate
  localparam logic [7:0] DEB_15K  = 8'h02;
  localparam logic [7:0] DEB_10K  = 8'h04;
  localparam logic [7:0] DEB_5K   = 8'h08;
  localparam logic [7:0] DEB_2K5  = 8'h10;
  localparam logic [7:0] DEB_1K   = 8'h28;
  localparam logic [7:0] DEB_RESET = DEB_15K;
  // debounce sample tick
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int DEB_TICK_PS     = 12_500_000;
  localparam int DEB_TICK_CYCLES = DEB_TICK_PS / CLK_PERIOD_PS;
endpackage

// file: design/dpc_sync.sv
/*
  dpc_sync: two-flop synchroniser for a group of pin levels.
  Assumes the pins are static for at least a few clocks.
*/
`timescale 1ns/1ps
module dpc_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // first flop feeds only the second
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// file: design/dpc_channel.sv
/*
  dpc_channel: one pulse counting channel with debounce and gating.
  Assumes synchronised inputs and a one-cycle debounce tick.
*/
`timescale 1ns/1ps
module dpc_channel
  import dpc_pkg::*;
(
  // clock, reset and debounce tick
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        tick_in,
  // software settings
  input  wire logic        soft_en_in,
  input  wire logic        soft_count_clear_in,
  input  wire logic        ext_enable_allow_in,
  input  wire logic        ext_clear_allow_in,
  input  wire logic [7:0]  debounce_code_in,
  // field levels
  input  wire logic        pulse_in,
  input  wire logic        ext_en_in,
  input  wire logic        ext_clr_in,
  // state
  output logic [31:0]      count_out
);
  logic       filt_r;
  logic [7:0] stab_r;
  wire        en_eff   = soft_en_in | (ext_enable_allow_in & ext_en_in);
  wire        clr_eff  = soft_count_clear_in | (ext_clear_allow_in & ext_clr_in);
  wire        differ   = pulse_in != filt_r;
  wire        settle   = differ && tick_in && (stab_r + 8'h01 >= debounce_code_in);
  wire        rise     = settle && pulse_in;

  // debounce: a new level must hold for debounce_code ticks
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      filt_r <= 1'b0;
      stab_r <= 8'h00;
    end else if (!differ || settle) begin
      filt_r <= pulse_in;
      stab_r <= 8'h00;
    end else if (tick_in) begin
      stab_r <= stab_r + 8'h01;
    end
  end

  // counter: clear wins, then count gated rising edges
  always_ff @(posedge clk_in) begin
    if (rst_in || clr_eff) begin
      count_out <= 32'h0000_0000;
    end else if (en_eff && rise) begin
      count_out <= count_out + 32'h0000_0001;
    end
  end

  a_clear_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    clr_eff |=> count_out == 32'h0000_0000) else $error("count not cleared");
  a_idle_frozen: assert property (@(posedge clk_in) disable iff (rst_in)
    !en_eff && !clr_eff |=> $stable(count_out)) else $error("disabled channel counted");
  a_edge_counts: assert property (@(posedge clk_in) disable iff (rst_in)
    en_eff && !clr_eff && rise |=> count_out == $past(count_out) + 32'h0000_0001)
    else $error("qualified edge not counted");
  a_ext_en_gate: assert property (@(posedge clk_in) disable iff (rst_in)
    !soft_en_in && !ext_enable_allow_in && !clr_eff |=> $stable(count_out))
    else $error("external enable acted while not allowed");
  a_ext_clr_gate: assert property (@(posedge clk_in) disable iff (rst_in)
    ext_clear_allow_in && ext_clr_in |=> count_out == 32'h0000_0000)
    else $error("allowed external clear ignored");
  a_soft_en_acts: assert property (@(posedge clk_in) disable iff (rst_in)
    soft_en_in && !clr_eff && rise |=> count_out != $past(count_out))
    else $error("soft enable did not enable");
  c_counted: cover property (@(posedge clk_in) disable iff (rst_in) en_eff && rise);
  c_ext_enabled: cover property (@(posedge clk_in) disable iff (rst_in)
    !soft_en_in && ext_enable_allow_in && ext_en_in && rise);
endmodule

// file: design/dpc_top.sv
/*
  dpc_top: dual pulse counter with general-purpose input points,
  reached over an AXI4-Lite slave port.
  Assumes field pins are asynchronous and a single 250 MHz clock.
*/
`timescale 1ns/1ps
module dpc_top
  import dpc_pkg::*;
(
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  // axi4-lite write address
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [7:0]         s_axi_awaddr,
  // axi4-lite write data
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  // axi4-lite write response
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  output logic [1:0]              s_axi_bresp,
  // axi4-lite read address
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  input  wire logic [7:0]         s_axi_araddr,
  // axi4-lite read data
  input  wire logic               s_axi_rvalid_unused_in,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  // field pins
  input  wire logic [FIELD_W-1:0] field_in
);
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // held write request
  logic        aw_full_r;
  logic [7:0]  aw_addr_r;
  logic        w_full_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  // software settings
  logic [15:0] ctrl_r;
  logic [15:0] debounce_r;
  logic [5:0]  gp_select_r;
  // pin state
  logic [FIELD_W-1:0] pins_sync;
  logic [FIELD_W-1:0] role_pins;
  logic [31:0]        count [NUM_CH];
  // debounce tick divider
  logic [15:0] tick_cnt_r;
  logic        tick_r;

  // handshake decisions
  wire aw_take   = s_axi_awvalid && s_axi_awready;
  wire w_take    = s_axi_wvalid && s_axi_wready;
  wire ar_take   = s_axi_arvalid && s_axi_arready;
  wire wr_fire   = aw_full_r && w_full_r && !s_axi_bvalid;
  assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // write address decoding
  wire wr_ctrl  = aw_addr_r == OFS_CTRL;
  wire wr_deb   = aw_addr_r == OFS_DEBOUNCE;
  wire wr_gp    = aw_addr_r == OFS_GP_SELECT;
  wire wr_ro    = aw_addr_r == OFS_COUNT1 || aw_addr_r == OFS_COUNT2
                  || aw_addr_r == OFS_POINTS;
  wire wr_hit   = wr_ctrl || wr_deb || wr_gp || wr_ro;

  // byte-lane merge for the 16-bit settings registers
  wire [15:0] ctrl_nxt = {w_strb_r[1] ? w_data_r[15:8] : ctrl_r[15:8],
                          w_strb_r[0] ? w_data_r[7:0]  : ctrl_r[7:0]};
  wire [15:0] deb_nxt  = {w_strb_r[1] ? w_data_r[15:8] : debounce_r[15:8],
                          w_strb_r[0] ? w_data_r[7:0]  : debounce_r[7:0]};

  // write address and data holding, taken in either order
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (aw_take) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
    end else if (wr_fire) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      w_full_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (w_take) begin
      w_full_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_r <= 1'b0;
    end
  end

  // settings registers; the channel fields in ctrl and debounce are write-only, gp_select reads back
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_r      <= CTRL_RESET;
      debounce_r  <= {DEB_RESET, DEB_RESET};
      gp_select_r <= GP_SELECT_RESET;
    end else if (wr_fire) begin
      if (wr_ctrl) begin
        ctrl_r <= ctrl_nxt;
      end else if (wr_deb) begin
        debounce_r <= deb_nxt;
      end else if (wr_gp && w_strb_r[0]) begin
        gp_select_r <= w_data_r[5:0];
      end
    end
  end

  // write response: unmapped offsets answer slverr
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read address decoding; write-only settings read as zero
  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
  wire rd_ctrl  = rd_addr == OFS_CTRL;
  wire rd_deb   = rd_addr == OFS_DEBOUNCE;
  wire rd_gp    = rd_addr == OFS_GP_SELECT;
  wire rd_c1    = rd_addr == OFS_COUNT1;
  wire rd_c2    = rd_addr == OFS_COUNT2;
  wire rd_pts   = rd_addr == OFS_POINTS;
  wire rd_hit   = rd_ctrl || rd_deb || rd_gp || rd_c1 || rd_c2 || rd_pts;
  wire [31:0] rd_val = rd_c1  ? count[0] :
                       rd_c2  ? count[1] :
                       rd_gp  ? {26'h000_0000, gp_select_r} :
                       rd_pts ? {24'h00_0000, pins_sync} :
                       32'h0000_0000;

  // read data register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // debounce sample tick, one cycle every DEB_TICK_CYCLES
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 16'(DEB_TICK_CYCLES - 1)) begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r     <= 1'b0;
    end
  end

  // pin synchroniser
  dpc_sync #(
    .W (FIELD_W)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (field_in),
    .sync_out (pins_sync)
  );

  // a pin given to the points shows as low to the counters
  assign role_pins = pins_sync & {2'b00, ~gp_select_r};

  // two independent channels
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    dpc_channel u_ch (
      .clk_in              (clk_in),
      .rst_in              (rst_in),
      .tick_in             (tick_r),
      .soft_en_in          (ctrl_r[c*CH_STRIDE + CTRL_SOFT_EN]),
      .soft_count_clear_in (ctrl_r[c*CH_STRIDE + CTRL_SOFT_CLR]),
      .ext_enable_allow_in (ctrl_r[c*CH_STRIDE + CTRL_EN_ALLOW]),
      .ext_clear_allow_in  (ctrl_r[c*CH_STRIDE + CTRL_CLR_ALLOW]),
      .debounce_code_in    (debounce_r[c*8 +: 8]),
      .pulse_in            (role_pins[c*PIN_STRIDE + PIN_PULSE]),
      .ext_en_in           (role_pins[c*PIN_STRIDE + PIN_EXT_EN]),
      .ext_clr_in          (role_pins[c*PIN_STRIDE + PIN_EXT_CLR]),
      .count_out           (count[c])
    );
  end

  a_debounce_boot: assert property (@(posedge clk_in)
    rst_in |=> debounce_r == {DEB_15K, DEB_15K}) else $error("debounce not 15 kHz after reset");
  a_count_readback: assert property (@(posedge clk_in) disable iff (rst_in)
    ar_take && rd_c2 |=> s_axi_rvalid && s_axi_rdata == $past(count[1]))
    else $error("count 2 read wrong");
  a_points_order: assert property (@(posedge clk_in) disable iff (rst_in)
    ar_take && rd_pts |=> s_axi_rdata[7:0] == $past(pins_sync) && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("points packed wrong");
  a_count_ro: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_fire && wr_ro |=> $stable(ctrl_r) && $stable(debounce_r) && $stable(gp_select_r))
    else $error("write to read-only offset changed settings");
  a_gp_masks: assert property (@(posedge clk_in) disable iff (rst_in)
    gp_select_r[0] |-> !role_pins[0]) else $error("gp pin still drives counter");
  a_bresp_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_write_answer: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_fire |=> s_axi_bvalid) else $error("write not answered");
  c_write_done: cover property (@(posedge clk_in) disable iff (rst_in) s_axi_bvalid && s_axi_bready);
  c_read_count: cover property (@(posedge clk_in) disable iff (rst_in) ar_take && rd_c1);
  c_bad_addr: cover property (@(posedge clk_in) disable iff (rst_in) ar_take && !rd_hit);
endmodule

// file: tb/dpc_field_model.sv
/*
  dpc_field_model: field side of the dual pulse counter, driving the
  pulse, external enable, external clear and general-purpose lines.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
module dpc_field_model (
  // clock
  input  wire logic       clk_in,
  // field lines
  output logic      [7:0] field_out
);
  logic [7:0] lines_r;

  // pins show the held levels; all lines idle low
  assign field_out = lines_r;
  initial lines_r = 8'h00;

  // static lines only; pulse pins 0 and 3 keep their level
  task automatic set_lines(input logic [7:0] v);
    @(posedge clk_in);
    lines_r <= (v & 8'hF6) | (lines_r & 8'h09);
  endtask

  // one whole pulse on the chosen channels, width cycles high then low
  task automatic pulse(input logic [1:0] ch, input int width);
    @(posedge clk_in);
    lines_r[0] <= ch[0];
    lines_r[3] <= ch[1];
    repeat (width) @(posedge clk_in);
    lines_r[0] <= 1'b0;
    lines_r[3] <= 1'b0;
    repeat (width) @(posedge clk_in);
  endtask
endmodule

// file: tb/dual_pulse_counter_tb.sv
/*
  dual_pulse_counter_tb: register and counting tests of dpc_top.
  Assumes the field model drives the pins and one 250 MHz clock.
*/
`timescale 1ns/1ps
module dual_pulse_counter_tb
  import dpc_pkg::*;
;
  localparam int WIDTH = 9000; // holds 2 debounce ticks, never 4
  logic        clk_in;
  logic        rst_in;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, field;
  logic [31:0] wdata, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb;
  logic        spare;
  int          failures, tests_run;

  dpc_top dut (
    .clk_in(clk_in), .rst_in(rst_in),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid_unused_in(spare), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .field_in(field)
  );

  dpc_field_model fm (.clk_in(clk_in), .field_out(field));

  // free-running clock, 4 ns period
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // compare one value and count it
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one write; readies are sampled half a cycle before the edge they act on
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, done;
    logic [1:0] br;
    int n;
    @(posedge clk_in);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    done = 1'b0;
    n = 0;
    while (!done && n < 200) begin
      @(negedge clk_in);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bready && bvalid;
      br = bresp;
      @(posedge clk_in);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, br});
  endtask

  // one read, data and response taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
                    input string name);
    logic ta, done;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    @(posedge clk_in);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    done = 1'b0;
    n = 0;
    while (!done && n < 200) begin
      @(negedge clk_in);
      ta = arvalid && arready;
      done = rready && rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_in);
      if (ta) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    check(name, exp, d);
    check("rresp", {30'h0, er}, {30'h0, r});
  endtask

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard: four pulses plus bus traffic stay well inside this span
  initial begin
    repeat (95000) @(posedge clk_in);
    failures++;
    conclude();
  end

  // main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    spare = 1'b0;
    failures = 0;
    tests_run = 0;
    rst_in = 1'b1;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    // values after reset, write-only places read zero
    rd(OFS_COUNT1, 32'h0000_0000, 2'b00, "count1");
    rd(OFS_COUNT2, 32'h0000_0000, 2'b00, "count2");
    rd(OFS_CTRL, 32'h0000_0000, 2'b00, "ctrl");
    rd(OFS_DEBOUNCE, 32'h0000_0000, 2'b00, "debounce");
    rd(OFS_GP_SELECT, 32'h0000_0000, 2'b00, "gp_select");
    rd(8'h18, 32'h0000_0000, 2'b10, "unmapped");
    wr(8'h18, 32'hFFFF_FFFF, 2'b10);
    wr(OFS_COUNT1, 32'h1234_5678, 2'b00);
    rd(OFS_COUNT1, 32'h0000_0000, 2'b00, "count1 ro");
    wr(OFS_GP_SELECT, 32'hFFFF_FFFF, 2'b00);
    rd(OFS_GP_SELECT, 32'h0000_003F, 2'b00, "gp_select six");
    // lane 0 off: the selection must keep its value
    wstrb <= 4'hE;
    wr(OFS_GP_SELECT, 32'h0000_0000, 2'b00);
    rd(OFS_GP_SELECT, 32'h0000_003F, 2'b00, "gp_select lane");
    wstrb <= 4'hF;
    wr(OFS_GP_SELECT, 32'h0000_0000, 2'b00);
    // packed points, point 0 lowest
    fm.set_lines(8'hF6);
    repeat (4) @(posedge clk_in);
    rd(OFS_POINTS, 32'h0000_00F6, 2'b00, "points");
    // ch1 soft enable, ch2 allowed external enable, default debounce
    fm.set_lines(8'h10);
    wr(OFS_CTRL, 32'h0000_0401, 2'b00);
    fm.pulse(2'b11, WIDTH);
    rd(OFS_COUNT1, 32'h0000_0001, 2'b00, "count1 p1");
    rd(OFS_COUNT2, 32'h0000_0001, 2'b00, "count2 p1");
    // ch1 soft enable cleared under external enable; ch2 not allowed
    fm.set_lines(8'h12);
    wr(OFS_CTRL, 32'h0000_0004, 2'b00);
    fm.pulse(2'b11, WIDTH);
    rd(OFS_COUNT1, 32'h0000_0002, 2'b00, "count1 p2");
    rd(OFS_COUNT2, 32'h0000_0001, 2'b00, "count2 p2");
    // ch1 soft clear held; ch2 pulse pin given to points, ext clear refused
    fm.set_lines(8'h22);
    wr(OFS_GP_SELECT, 32'h0000_0008, 2'b00);
    wr(OFS_CTRL, 32'h0000_0106, 2'b00);
    rd(OFS_COUNT1, 32'h0000_0000, 2'b00, "count1 clr");
    fm.pulse(2'b11, WIDTH);
    rd(OFS_COUNT1, 32'h0000_0000, 2'b00, "count1 p3");
    rd(OFS_COUNT2, 32'h0000_0001, 2'b00, "count2 p3");
    wr(OFS_CTRL, 32'h0000_0906, 2'b00);
    rd(OFS_COUNT2, 32'h0000_0000, 2'b00, "count2 ext clr");
    // ch1 debounce 4 rejects the short pulse, ch2 debounce 2 takes it
    fm.set_lines(8'h00);
    wr(OFS_GP_SELECT, 32'h0000_0000, 2'b00);
    wr(OFS_DEBOUNCE, {16'h0000, DEB_15K, DEB_10K}, 2'b00);
    wr(OFS_CTRL, 32'h0000_0101, 2'b00);
    fm.pulse(2'b11, WIDTH);
    rd(OFS_COUNT1, 32'h0000_0000, 2'b00, "count1 p4");
    rd(OFS_COUNT2, 32'h0000_0001, 2'b00, "count2 p4");
    conclude();
  end
endmodule
